// *** design/amcl_ctrl.sv ***
// Purpose: Controller end of a five-signal codec serial link.
// Assumes: Bit clock and serial inputs are synchronous to sys_clk_i.
// Notes:   The bit clock is sampled; its edges become enables.
//
// Our own choices: the placing of the registers and the plain strobed port.

`timescale 1ns/1ps

// Function
// - Audio side reaches codec registers 00h-3Ah and 5Ah-7Eh.
// - Modem side reaches codec registers 3Ch-58h and 5Ah-7Eh.
// - Send 16-bit stereo playback, left slot 3, right slot 4.
// - Take 16-bit stereo capture from input slots 3 and 4.
// - Take 16-bit mono microphone data from input slot 6.
// - Carry 16-bit modem line data both ways in slot 5.
// - Link reset output stays low until software releases it.
// - Sixteen GPIO bits move between slot 12 and registers.
// - Interrupt when slot 12 reports a GPIO input change.
// - Wake signal on either input line raises a wake event, only while the link reset is held.
// - Output slots 3, 4, 5 are sent only when requested.
// - Input slots 3 to 6 taken only when tagged valid.
// - Register accesses go to codec id 00 or 01.
// - Both input lines are ORed together, then taken apart.
// - Frame carries twelve 20-bit slots each way; two codecs max.
// - Data changes on bit clock rise, sampled on fall.
// - Sync is bit clock divided, high for 16 bit clocks.
// - Sync high is the tag phase, sync low the data phase.
// - Either codec on either line; wake kept per line.
// - Shutoff bit turns off every link output buffer.
// - Slot 0: frame valid bit 15, slot tags 14-3, id 1-0.
// - Sync rises on a rise; frame valid bit on next rise.
// - Send MSB first and fill invalid slots with zeros.
// - Optional codec test modes are not supported.
module amcl_ctrl
  import amcl_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic              clk_en_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  input  wire logic              serial_bit_clock_i,
  input  wire logic              serial_in_line0_i,
  input  wire logic              serial_in_line1_i,
  output logic                   serial_out_line_o,
  output logic                   serial_out_line_oe_o,
  output logic                   frame_sync_o,
  output logic                   frame_sync_oe_o,
  output logic                   codec_link_reset_out_n_o,
  output logic                   codec_link_reset_out_n_oe_o,
  output logic                   gpio_irq_o,
  output logic                   wake_event_o
);

  // ****************************************
  // State
  // ****************************************
  logic [2:0]  ctrl_ff;
  logic [18:0] cmd_ff;
  logic [15:0] cmd_data_ff;
  logic        cmd_pend_ff;
  logic        busy_ff;
  logic [15:0] pcm_l_ff;
  logic [15:0] pcm_r_ff;
  logic        pcm_pend_ff;
  logic [15:0] mdm_out_ff;
  logic        mdm_pend_ff;
  logic [15:0] gpio_out_ff;
  logic        gpio_on_ff;
  logic [7:0]  sticky_ff;
  logic [7:0]  stat_addr_ff;
  logic [15:0] stat_data_ff;
  logic [15:0] pcm_in_l_ff;
  logic [15:0] pcm_in_r_ff;
  logic [15:0] mic_in_ff;
  logic [15:0] mdm_in_ff;
  logic [15:0] gpio_in_ff;
  logic [31:0] rdata_ff;
  logic        bclk_q_ff;
  logic [3:0]  slot_ff;
  logic [4:0]  idx_ff;
  logic [3:0]  lslot_ff;
  logic [4:0]  lidx_ff;
  logic        sync_ff;
  logic        sdout_ff;
  logic [15:0] snap_tag_ff;
  logic [19:0] snap_s1_ff;
  logic [15:0] snap_s2_ff;
  logic [15:0] snap_l_ff;
  logic [15:0] snap_r_ff;
  logic [15:0] snap_m_ff;
  logic [15:0] snap_g_ff;
  logic [2:0]  slot_request_bits_n_ff;
  logic [18:0] rx_sh_ff;
  logic [15:0] rx_tag_ff;

  // ****************************************
  // Register port decode
  // ****************************************
  wire release_w = ctrl_ff[CTRL_RELEASE];
  wire shutoff_w = ctrl_ff[CTRL_SHUTOFF];
  wire wr_ctrl   = reg_wr_i && (reg_addr_i == REG_CTRL);
  wire wr_cmd    = reg_wr_i && (reg_addr_i == REG_CMD);
  wire wr_cdat   = reg_wr_i && (reg_addr_i == REG_CMD_DATA);
  wire wr_stat   = reg_wr_i && (reg_addr_i == REG_STATUS);
  wire wr_pcm    = reg_wr_i && (reg_addr_i == REG_PCM_OUT);
  wire wr_mdm    = reg_wr_i && (reg_addr_i == REG_MDM_OUT);
  wire wr_gpio   = reg_wr_i && (reg_addr_i == REG_GPIO_OUT);
  wire [7:0] new_addr = {reg_wdata_i[7:1], 1'b0};

  wire aud_ok = (new_addr <= AUD_HI) ||
                (new_addr >= VND_LO && new_addr <= VND_HI);
  wire mdm_ok = (new_addr >= MDM_LO && new_addr <= MDM_HI) ||
                (new_addr >= VND_LO && new_addr <= VND_HI);
  wire cmd_ok = reg_wdata_i[CMD_MODEM] ? mdm_ok : aud_ok;
  wire cmd_accept = wr_cmd && !busy_ff && cmd_ok;
  wire cmd_err    = wr_cmd && !(cmd_accept);

  wire [31:0] status_w = {21'h0, mdm_pend_ff, pcm_pend_ff,
                          busy_ff, sticky_ff};
  wire [31:0] rd_mux =
    (reg_addr_i == REG_CTRL)     ? {29'h0, ctrl_ff} :
    (reg_addr_i == REG_CMD)      ? {13'h0, cmd_ff} :
    (reg_addr_i == REG_CMD_DATA) ? {16'h0, cmd_data_ff} :
    (reg_addr_i == REG_STATUS)   ? status_w :
    (reg_addr_i == REG_STAT_DAT) ? {8'h0, stat_addr_ff, stat_data_ff} :
    (reg_addr_i == REG_PCM_OUT)  ? {pcm_r_ff, pcm_l_ff} :
    (reg_addr_i == REG_MDM_OUT)  ? {16'h0, mdm_out_ff} :
    (reg_addr_i == REG_PCM_IN)   ? {pcm_in_r_ff, pcm_in_l_ff} :
    (reg_addr_i == REG_MIC_MDM)  ? {mdm_in_ff, mic_in_ff} :
    (reg_addr_i == REG_GPIO_OUT) ? {16'h0, gpio_out_ff} :
    (reg_addr_i == REG_GPIO_IN)  ? {16'h0, gpio_in_ff} : 32'h0;

  // ****************************************
  // Link timing
  // ****************************************
  // external bit clock
  wire bclk_rise = serial_bit_clock_i && !bclk_q_ff && release_w;
  wire bclk_fall = !serial_bit_clock_i && bclk_q_ff && release_w;
  wire last_bit  = (idx_ff == 5'd0);
  wire [3:0] nxt_slot = !last_bit ? slot_ff :
                        (slot_ff == SLOT_LAST) ? 4'd0 : slot_ff + 4'd1;
  wire [4:0] nxt_idx  = !last_bit ? idx_ff - 5'd1 :
                        (nxt_slot == 4'd0) ? TAG_TOP : SLOT_TOP;
  wire snap_take = bclk_rise && (slot_ff == SLOT_LAST) && last_bit;

  wire send3 = pcm_pend_ff && !slot_request_bits_n_ff[2];
  wire send4 = pcm_pend_ff && !slot_request_bits_n_ff[1];
  wire send5 = mdm_pend_ff && !slot_request_bits_n_ff[0];
  wire send1 = cmd_pend_ff;
  wire send2 = cmd_pend_ff && !cmd_ff[CMD_READ];
  wire [11:0] tag_slots = {send1, send2, send3, send4, send5,
                           6'h0, gpio_on_ff};
  wire [1:0]  cmd_id  = cmd_ff[CMD_SEC] ? ID_SEC : ID_PRI;
  wire [15:0] nxt_tag = {|tag_slots, tag_slots, 1'b0, cmd_id};

  wire [19:0] tx_word =
    (slot_ff == 4'd0) ? {4'h0, snap_tag_ff} :
    (slot_ff == 4'd1) ? snap_s1_ff :
    (slot_ff == 4'd2) ? {snap_s2_ff, 4'h0} :
    (slot_ff == 4'd3) ? {snap_l_ff, 4'h0} :
    (slot_ff == 4'd4) ? {snap_r_ff, 4'h0} :
    (slot_ff == 4'd5) ? {snap_m_ff, 4'h0} :
    (slot_ff == SLOT_LAST) ? {snap_g_ff, 4'h0} : 20'h0;

  // ****************************************
  // Receive path
  // ****************************************
  // lines merged
  wire        rx_bit  = serial_in_line0_i | serial_in_line1_i;
  wire        rx_done = bclk_fall && (lidx_ff == 5'd0);
  wire [19:0] rx_word = {rx_sh_ff, rx_bit};
  wire [3:0]  tag_pos = 4'd15 - lslot_ff;
  wire rx_ok   = rx_done && (lslot_ff != 4'd0) && rx_tag_ff[tag_pos];
  wire rx_s3   = rx_ok && (lslot_ff == 4'd3);
  wire rx_s4   = rx_ok && (lslot_ff == 4'd4);
  wire rx_s5   = rx_ok && (lslot_ff == 4'd5);
  wire rx_s6   = rx_ok && (lslot_ff == 4'd6);
  wire rx_s12  = rx_ok && (lslot_ff == SLOT_LAST);
  wire rx_req  = rx_done && (lslot_ff == 4'd1) && rx_tag_ff[15];
  wire rx_s1   = rx_done && (lslot_ff == 4'd1) && rx_tag_ff[14];
  wire stat_take = rx_done && (lslot_ff == 4'd2) && rx_tag_ff[13] &&
                   busy_ff && cmd_ff[CMD_READ] && !cmd_pend_ff;
  wire wake0 = !release_w && serial_in_line0_i;
  wire wake1 = !release_w && serial_in_line1_i;
  wire gpio_chg = rx_s12 && rx_word[GPIO_INT_BIT];

  wire [7:0] st_set = {rx_s5, rx_s6, rx_s4, wake1, wake0,
                       gpio_chg, cmd_err, stat_take};
  wire [7:0] st_clr = wr_stat ? reg_wdata_i[7:0] : 8'h0;
  wire [7:0] nxt_sticky = st_set | (sticky_ff & ~st_clr);

  wire nxt_cmd_pend = cmd_accept || (cmd_pend_ff && !snap_take);
  wire nxt_busy = cmd_accept ||
                  (busy_ff && !(snap_take && send2) && !stat_take);
  wire nxt_pcm_pend = wr_pcm || (pcm_pend_ff && !(snap_take && send3));
  wire nxt_mdm_pend = wr_mdm || (mdm_pend_ff && !(snap_take && send5));
  wire nxt_gpio_on  = release_w && (wr_gpio || gpio_on_ff);

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ctrl_ff     <= CTRL_RST;
      cmd_ff      <= 19'h0;
      cmd_data_ff <= 16'h0;
      pcm_l_ff    <= 16'h0;
      pcm_r_ff    <= 16'h0;
      mdm_out_ff  <= 16'h0;
      gpio_out_ff <= 16'h0;
      rdata_ff    <= 32'h0;
    end else if (clk_en_i) begin
      if (wr_ctrl) ctrl_ff <= reg_wdata_i[2:0];
      if (cmd_accept) cmd_ff <= {reg_wdata_i[18:8], new_addr};
      if (wr_cdat && !busy_ff) cmd_data_ff <= reg_wdata_i[15:0];
      if (wr_pcm) pcm_l_ff <= reg_wdata_i[15:0];
      if (wr_pcm) pcm_r_ff <= reg_wdata_i[31:16];
      if (wr_mdm) mdm_out_ff <= reg_wdata_i[15:0];
      if (wr_gpio) gpio_out_ff <= reg_wdata_i[15:0];
      rdata_ff <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cmd_pend_ff <= 1'b0;
      busy_ff     <= 1'b0;
      pcm_pend_ff <= 1'b0;
      mdm_pend_ff <= 1'b0;
      gpio_on_ff  <= 1'b0;
      sticky_ff   <= 8'h0;
    end else if (clk_en_i) begin
      cmd_pend_ff <= nxt_cmd_pend;
      busy_ff     <= nxt_busy;
      pcm_pend_ff <= nxt_pcm_pend;
      mdm_pend_ff <= nxt_mdm_pend;
      gpio_on_ff  <= nxt_gpio_on;
      sticky_ff   <= nxt_sticky;
    end
  end

  // ****************************************
  // Frame transmit
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      bclk_q_ff <= 1'b0;
      slot_ff   <= SLOT_LAST;
      idx_ff    <= 5'd0;
      lslot_ff  <= SLOT_LAST;
      lidx_ff   <= 5'd0;
      sync_ff   <= 1'b0;
      sdout_ff  <= 1'b0;
    end else if (clk_en_i) begin
      bclk_q_ff <= serial_bit_clock_i;
      if (!release_w) begin
        slot_ff  <= SLOT_LAST;
        idx_ff   <= 5'd0;
        sync_ff  <= 1'b0;
        sdout_ff <= 1'b0;
      end else if (bclk_rise) begin
        slot_ff  <= nxt_slot;
        idx_ff   <= nxt_idx;
        lslot_ff <= slot_ff;
        lidx_ff  <= idx_ff;
        sync_ff  <= (nxt_slot == 4'd0);
        sdout_ff <= tx_word[idx_ff];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      snap_tag_ff <= 16'h0;
      snap_s1_ff  <= 20'h0;
      snap_s2_ff  <= 16'h0;
      snap_l_ff   <= 16'h0;
      snap_r_ff   <= 16'h0;
      snap_m_ff   <= 16'h0;
      snap_g_ff   <= 16'h0;
    end else if (clk_en_i && snap_take) begin
      snap_tag_ff <= nxt_tag;
      snap_s1_ff  <= send1 ? {cmd_ff[CMD_READ], cmd_ff[7:1], 12'h0}
                           : 20'h0;
      snap_s2_ff  <= send2 ? cmd_data_ff : 16'h0;
      snap_l_ff   <= send3 ? pcm_l_ff : 16'h0;
      snap_r_ff   <= send4 ? pcm_r_ff : 16'h0;
      snap_m_ff   <= send5 ? mdm_out_ff : 16'h0;
      snap_g_ff   <= gpio_on_ff ? gpio_out_ff : 16'h0;
    end
  end

  // ****************************************
  // Frame receive
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_sh_ff     <= 19'h0;
      rx_tag_ff    <= 16'h0;
      slot_request_bits_n_ff <= 3'h7;
    end else if (clk_en_i && bclk_fall) begin
      rx_sh_ff <= rx_word[18:0];
      if (rx_done && lslot_ff == 4'd0) rx_tag_ff <= rx_word[15:0];
      if (rx_req) begin
        slot_request_bits_n_ff <= {rx_word[REQ_S3], rx_word[REQ_S4],
                         rx_word[REQ_S5]};
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      stat_addr_ff <= 8'h0;
      stat_data_ff <= 16'h0;
      pcm_in_l_ff  <= 16'h0;
      pcm_in_r_ff  <= 16'h0;
      mic_in_ff    <= 16'h0;
      mdm_in_ff    <= 16'h0;
      gpio_in_ff   <= 16'h0;
    end else if (clk_en_i) begin
      if (rx_s1) stat_addr_ff <= {rx_word[18:12], 1'b0};
      if (stat_take) stat_data_ff <= rx_word[19:4];
      if (rx_s3) pcm_in_l_ff <= rx_word[19:4];
      if (rx_s4) pcm_in_r_ff <= rx_word[19:4];
      if (rx_s6) mic_in_ff <= rx_word[19:4];
      if (rx_s5) mdm_in_ff <= rx_word[19:4];
      if (rx_s12) gpio_in_ff <= rx_word[19:4];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Shutoff only floats the pins; internal state keeps running.
  assign reg_rdata_o                 = rdata_ff;
  assign serial_out_line_o           = sdout_ff;
  assign frame_sync_o                = sync_ff;
  assign codec_link_reset_out_n_o    = release_w;
  assign serial_out_line_oe_o        = !shutoff_w;
  assign frame_sync_oe_o             = !shutoff_w;
  assign codec_link_reset_out_n_oe_o = !shutoff_w;
  assign gpio_irq_o = sticky_ff[ST_GPIO_CHG] && ctrl_ff[CTRL_GPIO_IE];
  assign wake_event_o = sticky_ff[ST_WAKE0] || sticky_ff[ST_WAKE1];

  // ****************************************
  // Checks
  // ****************************************
  logic [4:0] hi_cnt_ff;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hi_cnt_ff <= 5'd0;
    end else if (clk_en_i) begin
      if (bclk_rise && sync_ff) hi_cnt_ff <= hi_cnt_ff + 5'd1;
      else if (!sync_ff) hi_cnt_ff <= 5'd0;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence frame_start_s;
    clk_en_i && bclk_rise && slot_ff == 4'd0 && idx_ff == TAG_TOP;
  endsequence

  sync_width_a: assert property (
    $fell(sync_ff) |-> hi_cnt_ff == SYNC_BITS)
    else $error("sync high time is not 16 bit clocks");

  reset_hold_a: assert property (
    !release_w && $past(!release_w && clk_en_i) |->
    !codec_link_reset_out_n_o && !sync_ff)
    else $error("link reset left low state without release");

  shutoff_pins_a: assert property (
    shutoff_w |-> !serial_out_line_oe_o && !frame_sync_oe_o &&
                  !codec_link_reset_out_n_oe_o)
    else $error("link buffer on during shutoff");

  frame_valid_a: assert property (
    frame_start_s |=> sync_ff && sdout_ff == snap_tag_ff[15])
    else $error("frame valid bit not first after sync");

  zero_fill_a: assert property (
    clk_en_i && bclk_rise && slot_ff != 4'd0 &&
    !snap_tag_ff[4'd15 - slot_ff] |=> !sdout_ff)
    else $error("invalid slot not zero filled");

  slot_req_a: assert property (
    clk_en_i && snap_take && slot_request_bits_n_ff[2] |=> !snap_tag_ff[12])
    else $error("slot 3 sent without request");

  rx_tag_a: assert property (
    clk_en_i && !$stable(pcm_in_l_ff) |-> $past(rx_tag_ff[12]))
    else $error("capture taken from untagged slot");

  codec_id_a: assert property (
    clk_en_i && snap_take |=> snap_tag_ff[1] == 1'b0)
    else $error("codec id outside 00 and 01");

  gpio_keep_a: assert property (
    clk_en_i && gpio_on_ff && release_w |=> gpio_on_ff)
    else $error("slot 12 dropped while link running");

endmodule : amcl_ctrl

// *** design/amcl_pkg.sv ***
// Purpose: Constants for the codec link controller.
// Assumes: 32-bit register port, word-aligned byte offsets.
// Notes:   One number, one name; the module imports all of it.

package amcl_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int         ADDR_W       = 6;
  localparam logic [5:0] REG_CTRL     = 6'h00;
  localparam logic [5:0] REG_CMD      = 6'h04;
  localparam logic [5:0] REG_CMD_DATA = 6'h08;
  localparam logic [5:0] REG_STATUS   = 6'h0c;
  localparam logic [5:0] REG_STAT_DAT = 6'h10;
  localparam logic [5:0] REG_PCM_OUT  = 6'h14;
  localparam logic [5:0] REG_MDM_OUT  = 6'h18;
  localparam logic [5:0] REG_PCM_IN   = 6'h1c;
  localparam logic [5:0] REG_MIC_MDM  = 6'h20;
  localparam logic [5:0] REG_GPIO_OUT = 6'h24;
  localparam logic [5:0] REG_GPIO_IN  = 6'h28;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int         CTRL_RELEASE = 0;
  localparam int         CTRL_SHUTOFF = 1;
  localparam int         CTRL_GPIO_IE = 2;
  localparam logic [2:0] CTRL_RST     = 3'h0;
  localparam int         CMD_READ     = 16;
  localparam int         CMD_SEC      = 17;
  localparam int         CMD_MODEM    = 18;
  localparam int         ST_STAT_V    = 0;
  localparam int         ST_CMD_ERR   = 1;
  localparam int         ST_GPIO_CHG  = 2;
  localparam int         ST_WAKE0     = 3;
  localparam int         ST_WAKE1     = 4;
  localparam int         ST_PCM_NEW   = 5;
  localparam int         ST_MIC_NEW   = 6;
  localparam int         ST_MDM_NEW   = 7;

  // ****************************************
  // Link frame layout
  // ****************************************
  localparam logic [3:0] SLOT_LAST    = 4'd12;
  localparam logic [4:0] TAG_TOP      = 5'd15;
  localparam logic [4:0] SLOT_TOP     = 5'd19;
  localparam int         REQ_S3       = 11;
  localparam int         REQ_S4       = 10;
  localparam int         REQ_S5       = 9;
  localparam int         GPIO_INT_BIT = 0;
  localparam logic [4:0] SYNC_BITS    = 5'd16;
  localparam logic [1:0] ID_PRI       = 2'b00;
  localparam logic [1:0] ID_SEC       = 2'b01;

  // ****************************************
  // Codec register ranges
  // ****************************************
  localparam logic [7:0] AUD_LO = 8'h00;
  localparam logic [7:0] AUD_HI = 8'h3a;
  localparam logic [7:0] MDM_LO = 8'h3c;
  localparam logic [7:0] MDM_HI = 8'h58;
  localparam logic [7:0] VND_LO = 8'h5a;
  localparam logic [7:0] VND_HI = 8'h7e;
endpackage : amcl_pkg

// *** testbench/amcl_codec_model.sv ***
// Purpose: Behavioural codec on the far side of the serial link.
// Assumes: Bit clock is sys_clk_i divided by four, stopped in link reset.
// Notes:   A register read is answered in the very next frame.
`timescale 1ns/1ps
module amcl_codec_model (
  input  wire logic        sys_clk_i,
  input  wire logic        link_reset_n_i,
  input  wire logic        sync_i,
  input  wire logic        sdout_i,
  input  wire logic        tag_on_i,
  input  wire logic        gchg_i,
  input  wire logic [2:0]  req_n_i,
  input  wire logic [15:0] smp_i,
  output logic             bclk_o,
  output logic             codec_input_line_o,
  output logic [19:0]      got_o [13],
  output logic [15:0]      cmd_tag_o,
  output logic [8:0]       flen_o,
  output logic [4:0]       shi_o
);
  logic [1:0]   div_ff  = '0;
  logic [7:0]   pos_ff  = '0;
  logic [8:0]   fcnt_ff = '0;
  logic [4:0]   hcnt_ff = '0;
  logic         syq_ff  = 1'b0;
  logic [255:0] in_ff   = '0;
  logic [255:0] out_ff  = '0;
  logic [255:0] of, nf;

  initial foreach (got_o[i]) got_o[i] = '0;

  always @(posedge sys_clk_i) begin
    if (!link_reset_n_i) begin
      div_ff <= '0;
      bclk_o <= 1'b0;
      codec_input_line_o <= 1'b0;
    end else begin
      div_ff <= div_ff + 2'd1;
      bclk_o <= !div_ff[1];
      if (div_ff == 2'd0) codec_input_line_o <= in_ff[8'd255 - pos_ff];
      if (div_ff == 2'd2) begin
        of = out_ff;
        of[8'd255 - pos_ff] = sdout_i;
        out_ff <= of;
        syq_ff <= sync_i;
        hcnt_ff <= sync_i ? hcnt_ff + 5'd1 : 5'd0;
        if (!sync_i && syq_ff) shi_o <= hcnt_ff;
        pos_ff <= pos_ff + 8'd1;
        fcnt_ff <= fcnt_ff + 9'd1;
        if (sync_i && !syq_ff) begin
          pos_ff <= '0;
          fcnt_ff <= 9'd1;
          flen_o <= fcnt_ff;
          for (int s = 1; s < 13; s++)
            if (of[255] && of[255 - s]) got_o[s] <= of[259 - 20 * s -: 20];
          if (of[254]) cmd_tag_o <= of[255:240];
          nf = '0;
          nf[255] = 1'b1;
          nf[243] = 1'b1;
          nf[252:249] = {4{tag_on_i}};
          nf[239:220] = {1'b0, of[238:232], req_n_i, 9'h0};
          if (of[255] && of[254] && of[239]) begin
            nf[254:253] = 2'b11;
            nf[219:200] = {8'hc3, of[238:232], 1'b0, 4'h0};
          end
          for (int s = 3; s < 7; s++)
            nf[259 - 20 * s -: 20] = {smp_i + 16'(s), 4'h0};
          nf[19:0] = {smp_i, 3'h0, gchg_i};
          in_ff <= nf;
        end
      end
    end
  end
endmodule : amcl_codec_model

// *** testbench/test_audio_modem_codec_link_controller.sv ***
// Purpose: Self-checking bench for the codec link controller.
// Assumes: The codec model makes the bit clock from sys_clk_i.
// Notes:   Bit clock is a quarter of sys_clk_i so sampled edges stay clean.
`timescale 1ns/1ps
module test_audio_modem_codec_link_controller;
  import amcl_pkg::*;
  typedef struct packed {logic err; logic [2:0] fn; logic [7:0] a;} amcl_row_t;
  logic              sys_clk_i = 1'b0, reset_i = 1'b1;
  logic              reg_wr = 1'b0, reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0]       reg_wdata = '0, rdata;
  logic              bclk, codec_input_line, sdout, sdout_oe, sync, sync_oe;
  logic              rst_n, rst_oe, irq, wake;
  logic              wake1 = 1'b0, tag_on = 1'b0, gchg = 1'b0;
  logic              clk_en = 1'b1;
  logic [2:0]        req_n = 3'b111;
  logic [15:0]       smp = '0, cmd_tag;
  logic [19:0]       got [13];
  logic [8:0]        flen;
  logic [4:0]        shi;
  int                failures = 0, total_checks = 0;
  amcl_row_t         rows [9] = '{'{1'b0, 3'b001, 8'h00},
    '{1'b0, 3'b001, 8'h3a}, '{1'b1, 3'b001, 8'h3c}, '{1'b0, 3'b101, 8'h3c},
    '{1'b0, 3'b111, 8'h58}, '{1'b1, 3'b100, 8'h3a}, '{1'b0, 3'b000, 8'h7e},
    '{1'b0, 3'b110, 8'h5a}, '{1'b1, 3'b000, 8'h80}};
  // Released pins fall to their weak pull-downs.
  wire sdout_pin = sdout_oe ? sdout : 1'b0;
  wire sync_pin  = sync_oe ? sync : 1'b0;
  wire rst_pin   = rst_oe ? rst_n : 1'b0;

  always #20 sys_clk_i = ~sys_clk_i;

  amcl_ctrl u_amcl_ctrl (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
    .serial_bit_clock_i(bclk), .serial_in_line0_i(codec_input_line),
    .serial_in_line1_i(wake1), .serial_out_line_o(sdout),
    .serial_out_line_oe_o(sdout_oe), .frame_sync_o(sync),
    .frame_sync_oe_o(sync_oe), .codec_link_reset_out_n_o(rst_n),
    .codec_link_reset_out_n_oe_o(rst_oe), .gpio_irq_o(irq),
    .wake_event_o(wake));

  amcl_codec_model u_amcl_codec_model (.sys_clk_i(sys_clk_i),
    .link_reset_n_i(rst_pin), .sync_i(sync_pin), .sdout_i(sdout_pin),
    .tag_on_i(tag_on), .gchg_i(gchg), .req_n_i(req_n), .smp_i(smp),
    .bclk_o(bclk), .codec_input_line_o(codec_input_line), .got_o(got), .cmd_tag_o(cmd_tag),
    .flen_o(flen), .shi_o(shi));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic conclude;
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk_i);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk_i);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic frames(input int n);
    repeat (n * 1024 + 64) @(posedge sys_clk_i);
    #1;
  endtask : frames

  task automatic waitst(input int b, input logic v);
    logic [31:0] d;
    for (int i = 0; i < 60; i++) begin
      rd(REG_STATUS, d);
      if (d[b] === v) return;
      repeat (256) @(posedge sys_clk_i);
    end
    failures++;
    $display("FAIL %0t: status wait ran out", $time);
    conclude();
  endtask : waitst

  initial begin
    logic [31:0] d;
    amcl_row_t   r;
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk({sdout_oe, sync_oe, rst_oe, sync, irq, wake, rst_n}, 7'h70);
    chk(rdata, 0);
    wr(6'h3c, 32'hffff_ffff);
    rd(6'h3c, d);
    chk(d, 0);
    rd(REG_STATUS, d);
    chk(d, 0);
    wake1 <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    wake1 <= 1'b0;
    rd(REG_STATUS, d);
    chk(d[4:3], 2'b10);
    chk(wake, 1);
    wr(REG_STATUS, 32'h10);
    rd(REG_CTRL, d);
    chk({d[2:0], wake, rst_n}, 0);
    wr(REG_CTRL, 32'h5);
    frames(3);
    chk({shi, flen}, {5'd16, 9'd256});
    foreach (rows[i]) begin
      r = rows[i];
      wr(REG_CMD_DATA, {16'h0, 8'h5e, r.a});
      wr(REG_CMD, {13'h0, r.fn, 8'h0, r.a});
      if (r.err) begin
        rd(REG_STATUS, d);
        chk(d[ST_CMD_ERR], 1);
        wr(REG_STATUS, 32'h2);
      end else begin
        waitst(8, 1'b0);
        frames(1);
        rd(REG_STATUS, d);
        chk(d[ST_STAT_V], r.fn[0]);
        chk({cmd_tag[14], cmd_tag[1:0]}, {2'b10, r.fn[1]});
        chk(got[1], {r.fn[0], r.a[7:1], 12'h0});
        if (r.fn[0]) begin
          rd(REG_STAT_DAT, d);
          chk(d, {8'h0, r.a, 8'hc3, r.a});
          wr(REG_STATUS, 32'h1);
        end else chk(got[2], {8'h5e, r.a, 4'h0});
      end
    end
    wr(REG_PCM_OUT, 32'h2222_1111);
    wr(REG_MDM_OUT, 32'h3333);
    frames(3);
    rd(REG_STATUS, d);
    chk({d[10:9], got[3]}, {2'b11, 20'h0});
    req_n <= 3'b000;
    waitst(9, 1'b0);
    waitst(10, 1'b0);
    frames(1);
    chk(got[3], 20'h11110);
    chk(got[4], 20'h22220);
    chk(got[5], 20'h33330);
    smp <= 16'h4000;
    tag_on <= 1'b1;
    frames(3);
    rd(REG_PCM_IN, d);
    chk(d, 32'h4004_4003);
    rd(REG_MIC_MDM, d);
    chk(d, 32'h4005_4006);
    rd(REG_STATUS, d);
    chk(d[7:5], 3'b111);
    smp <= 16'h7000;
    tag_on <= 1'b0;
    frames(3);
    rd(REG_PCM_IN, d);
    chk(d, 32'h4004_4003);
    wr(REG_GPIO_OUT, 32'hbeef);
    frames(2);
    chk(got[12], 20'hbeef0);
    rd(REG_GPIO_IN, d);
    chk(d, 32'h7000);
    gchg <= 1'b1;
    frames(2);
    chk(irq, 1);
    wr(REG_CTRL, 32'h1);
    rd(REG_STATUS, d);
    chk({irq, d[ST_GPIO_CHG]}, 2'b01);
    wr(REG_CTRL, 32'h3);
    rd(REG_CTRL, d);
    chk({sdout_oe, sync_oe, rst_oe}, 0);
    @(posedge sys_clk_i);
    clk_en <= 1'b0;
    wr(REG_MDM_OUT, 32'h5555);
    clk_en <= 1'b1;
    rd(REG_MDM_OUT, d);
    chk(d, 32'h3333);
    conclude();
  end
endmodule : test_audio_modem_codec_link_controller
